//--- slpwk_defines.svh
// constants for the always-on sleep and wake-up control block
// assumes inclusion by bare name from every design file that needs them
`ifndef SLPWK_DEFINES_SVH
`define SLPWK_DEFINES_SVH

// oscillator indices, equal to the counter clock select codes
`define SLPWK_OSC_XT32K     0
`define SLPWK_OSC_IRC128K   1
`define SLPWK_OSC_IRC16M    2
`define SLPWK_OSC_XOSC      3

// prescaler divisors per source
`define SLPWK_DIV_32K       10'h020
`define SLPWK_DIV_128K      10'h080
`define SLPWK_DIV_16M       10'h200
`define SLPWK_DIV_NONE      10'h001

// counter field compared against the match value
`define SLPWK_MATCH_LSB     10
`define SLPWK_MATCH_MSB     21

// system clock select code of the 16 MHz internal oscillator, also reset value
`define SLPWK_SYSCLK_IRC16M 2'h0
// wake sync clock select value for the 128 kHz oscillator
`define SLPWK_WAKE_SYNC_CLOCK_SELECT_128K    1'h1

`endif

//--- slpwk_pkg.sv
// types shared by the sleep and wake-up control block
// assumes slpwk_defines.svh for the constants
package slpwk_pkg;

	typedef enum logic [1:0] {
		st_run,
		st_sleep,
		st_wake
	} slpwk_state_e;

	// software configuration, held on plain ports
	typedef struct packed {
		logic        counter_enable;
		logic [1:0]  counter_clock_select;
		logic        fast_div512;
		logic        counter_wake_enable;
		logic        rollover_wake_enable;
		logic [11:0] counter_match_value;
		logic        pit_enable;
		logic        pit_wake_enable;
		logic [9:0]  pit_compare;
		logic        wake_sync_clock_select;
		logic        slow_osc_sleep_keep;
		logic [31:0] pin_wake_enable;
		logic [31:0] pin_rise_select;
		logic [31:0] pin_fall_select;
	} slpwk_cfg_s;

	typedef struct packed {
		logic match;
		logic rollover;
		logic pit;
		logic pin;
	} slpwk_cause_s;

endpackage

//--- slpwk_pin_wake.sv
// per-pin synchroniser and edge detector for the wake pins
// assumes i_sample is a one-cycle strobe of the chosen sampling oscillator
`timescale 1ns/10ps
module slpwk_pin_wake (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [31:0] i_pins,
	input  wire logic        i_sample,
	input  wire logic [31:0] i_enable,
	input  wire logic [31:0] i_rise,
	input  wire logic [31:0] i_fall,
	output logic      [31:0] o_wake
);

	logic [31:0] sync1_q;
	logic [31:0] sync2_q;
	logic [31:0] prev_q;
	logic [31:0] armed_q;

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_pin
			// two flops against metastability, only the second flop reads the first
			always_ff @(posedge i_clk) begin
				if (!i_reset_n) begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
				end else begin
					sync1_q[g] <= i_pins[g];
					sync2_q[g] <= sync1_q[g];
				end
			end

			// edge seen only at a sampling strobe, so latency is one sample period
			always_ff @(posedge i_clk) begin
				if (!i_reset_n) begin
					prev_q[g]  <= 1'b0;
					armed_q[g] <= 1'b0;
					o_wake[g]  <= 1'b0;
				end else begin
					o_wake[g] <= 1'b0;
					if (i_sample) begin
						prev_q[g]  <= sync2_q[g];
						armed_q[g] <= 1'b1;
						// first sample only arms, so a high pin gives no false rise
						o_wake[g] <= armed_q[g] & i_enable[g] &
							((i_rise[g] & sync2_q[g] & ~prev_q[g]) |
							 (i_fall[g] & ~sync2_q[g] & prev_q[g]));
					end
				end
			end
		end
	endgenerate

endmodule

//--- slpwk_ctrl.sv
// always-on sleep entry and wake-up controller: wake timer, periodic timer,
// pin wake, halt handshakes and clock selection around sleep
// assumes one 40 MHz clock; oscillator lines arrive unsynchronised as levels
`include "slpwk_defines.svh"
`timescale 1ns/10ps
module slpwk_ctrl (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset_n,
	input  wire logic [3:0]             i_osc,
	input  wire slpwk_pkg::slpwk_cfg_s  i_cfg,
	input  wire logic [31:0]            i_pins,
	input  wire logic                   i_sleep_req,
	input  wire logic [1:0]             i_core_active,
	input  wire logic [1:0]             i_core_wait,
	input  wire logic                   i_sysclk_load,
	input  wire logic [1:0]             i_sysclk_sel,
	input  wire logic [31:0]            i_halt_req,
	input  wire logic [31:0]            i_periph_idle,
	input  wire slpwk_pkg::slpwk_cause_s i_cause_clear,
	output logic                        o_sleep,
	output logic                        o_wake_req,
	output logic [1:0]                  o_resume_core,
	output logic [1:0]                  o_sysclk_sel,
	output logic                        o_irc16m_en,
	output logic                        o_prev_clk_keep,
	output logic                        o_irc128k_en,
	output logic [31:0]                 o_halt_req,
	output logic [31:0]                 o_halt_ack,
	output slpwk_pkg::slpwk_cause_s     o_cause,
	output logic [31:0]                 o_counter
);

	slpwk_pkg::slpwk_state_e state_q;
	slpwk_pkg::slpwk_state_e state_d;
	slpwk_pkg::slpwk_cfg_s   cfg_q;

	logic [3:0]  osc_s1_q;
	logic [3:0]  osc_s2_q;
	logic [3:0]  osc_s3_q;
	logic [3:0]  osc_edge;
	logic        src_edge;
	logic [9:0]  div_m1;
	logic [9:0]  pre_q;
	logic        ms_tick;
	logic [31:0] cnt_q;
	logic [31:0] cnt_nxt;
	logic [9:0]  pit_q;
	logic        ev_match_q;
	logic        ev_roll_q;
	logic        ev_pit_q;
	logic [31:0] pin_wake;
	logic        sample;
	logic        wake_any;
	logic        enter;
	logic [1:0]  waited_q;
	slpwk_pkg::slpwk_cause_s cause_set;

	// oscillator lines: two flops, then a third for edge detection
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_osc
			always_ff @(posedge i_clk) begin
				if (!i_reset_n) begin
					osc_s1_q[g] <= 1'b0;
					osc_s2_q[g] <= 1'b0;
					osc_s3_q[g] <= 1'b0;
				end else begin
					osc_s1_q[g] <= i_osc[g];
					osc_s2_q[g] <= osc_s1_q[g];
					osc_s3_q[g] <= osc_s2_q[g];
				end
			end
			assign osc_edge[g] = osc_s2_q[g] & ~osc_s3_q[g];
		end
	endgenerate

	// counter source mux and prescaler per source; the 16 MHz source divides by 512 only with fast_div512, else by 1
	assign src_edge = osc_edge[cfg_q.counter_clock_select];
	always_comb begin
		div_m1 = `SLPWK_DIV_NONE - 10'h001;
		unique case (cfg_q.counter_clock_select)
			2'h0: div_m1 = `SLPWK_DIV_32K - 10'h001;
			2'h1: div_m1 = `SLPWK_DIV_128K - 10'h001;
			2'h2: div_m1 = cfg_q.fast_div512 ? `SLPWK_DIV_16M - 10'h001 : 10'h000;
			2'h3: div_m1 = `SLPWK_DIV_NONE - 10'h001;
		endcase
	end
	assign ms_tick = cfg_q.counter_enable & src_edge & (pre_q == div_m1);

	// prescaler count, cleared while the counter is off
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !cfg_q.counter_enable) begin
			pre_q <= 10'h000;
		end else if (ms_tick) begin
			pre_q <= 10'h000;
		end else if (src_edge) begin
			pre_q <= pre_q + 10'h001;
		end
	end

	// free-running wake counter; holds its value while disabled
	assign cnt_nxt = cnt_q + 32'h00000001;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cnt_q <= 32'h00000000;
		end else if (ms_tick) begin
			cnt_q <= cnt_nxt;
		end
	end

	// match and rollover events, one cycle each, aligned with the count
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ev_match_q <= 1'b0;
			ev_roll_q  <= 1'b0;
		end else begin
			// 12-bit match on bits 10..21 gives roughly one-second steps with the 32 kHz and 128 kHz sources
			ev_match_q <= ms_tick &
				(cnt_nxt[`SLPWK_MATCH_MSB:`SLPWK_MATCH_LSB] == cfg_q.counter_match_value) &
				(cnt_nxt[`SLPWK_MATCH_LSB-1:0] == 10'h000);
			ev_roll_q <= ms_tick & (cnt_q == 32'hffffffff);
		end
	end

	// periodic timer: compare+1 ticks per event, only with the counter enabled
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !(cfg_q.counter_enable && cfg_q.pit_enable)) begin
			pit_q    <= 10'h000;
			ev_pit_q <= 1'b0;
		end else begin
			ev_pit_q <= 1'b0;
			if (ms_tick) begin
				if (pit_q == cfg_q.pit_compare) begin
					pit_q    <= 10'h000;
					ev_pit_q <= 1'b1;
				end else begin
					pit_q <= pit_q + 10'h001;
				end
			end
		end
	end

	// pin sampling clock: 16 MHz or 128 kHz oscillator strobe
	assign sample = (cfg_q.wake_sync_clock_select == `SLPWK_WAKE_SYNC_CLOCK_SELECT_128K) ?
		osc_edge[`SLPWK_OSC_IRC128K] : osc_edge[`SLPWK_OSC_IRC16M];

	slpwk_pin_wake u_pin_wake (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_pins    (i_pins),
		.i_sample  (sample),
		.i_enable  (cfg_q.pin_wake_enable),
		.i_rise    (cfg_q.pin_rise_select),
		.i_fall    (cfg_q.pin_fall_select),
		.o_wake    (pin_wake)
	);

	// each source gated by its own enable; nothing enabled means no wake
	assign cause_set.match    = ev_match_q & cfg_q.counter_wake_enable;
	assign cause_set.rollover = ev_roll_q & cfg_q.rollover_wake_enable;
	assign cause_set.pit      = ev_pit_q & cfg_q.pit_wake_enable;
	assign cause_set.pin      = |pin_wake;
	assign wake_any = |cause_set;

	// configuration follows the ports in run and is frozen during sleep
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cfg_q <= '0;
		end else if (state_q == slpwk_pkg::st_run) begin
			cfg_q <= i_cfg;
		end
	end

	// sleep entry needs the sleep bit and every active core in wait
	assign enter = i_sleep_req & (i_core_active != 2'h0) &
		((i_core_wait & i_core_active) == i_core_active);

	// low-power state machine
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			slpwk_pkg::st_run:   if (enter) state_d = slpwk_pkg::st_sleep;
			slpwk_pkg::st_sleep: if (wake_any) state_d = slpwk_pkg::st_wake;
			slpwk_pkg::st_wake:  state_d = slpwk_pkg::st_run;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_q <= slpwk_pkg::st_run;
			o_sleep <= 1'b0;
		end else begin
			state_q <= state_d;
			o_sleep <= (state_d == slpwk_pkg::st_sleep);
		end
	end

	// remember which cores waited; they resume at their recovery vectors
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			waited_q      <= 2'h0;
			o_resume_core <= 2'h0;
			o_wake_req    <= 1'b0;
		end else begin
			if (state_q == slpwk_pkg::st_run && enter) begin
				waited_q <= i_core_wait & i_core_active;
			end
			o_wake_req    <= (state_q == slpwk_pkg::st_sleep) & wake_any;
			o_resume_core <= (state_q == slpwk_pkg::st_wake) ? waited_q : 2'h0;
		end
	end

	// wake cause flags; a new event beats a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_cause <= '0;
		end else begin
			o_cause <= (o_cause & ~i_cause_clear) |
				((state_q == slpwk_pkg::st_sleep) ? cause_set : 4'h0);
		end
	end

	// system clock select: software loads it in run, forced to 16 MHz at entry
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_sysclk_sel <= `SLPWK_SYSCLK_IRC16M;
		end else if (state_q == slpwk_pkg::st_run && enter) begin
			o_sysclk_sel <= `SLPWK_SYSCLK_IRC16M;
		end else if (state_q == slpwk_pkg::st_run && i_sysclk_load) begin
			o_sysclk_sel <= i_sysclk_sel;
		end
	end

	// oscillator enables; the old source stays on, costing power, by design
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_irc16m_en     <= 1'b1;
			o_prev_clk_keep <= 1'b0;
			o_irc128k_en    <= 1'b1;
		end else begin
			if (state_q == slpwk_pkg::st_run && enter) begin
				o_prev_clk_keep <= (o_sysclk_sel != `SLPWK_SYSCLK_IRC16M);
			end else if (state_d == slpwk_pkg::st_run) begin
				o_prev_clk_keep <= 1'b0;
			end
			o_irc16m_en <= (state_d != slpwk_pkg::st_run) |
				(o_sysclk_sel == `SLPWK_SYSCLK_IRC16M) |
				(cfg_q.counter_clock_select == 2'h2);
			o_irc128k_en <= (state_d == slpwk_pkg::st_run) | cfg_q.slow_osc_sleep_keep |
				(cfg_q.wake_sync_clock_select == `SLPWK_WAKE_SYNC_CLOCK_SELECT_128K);
		end
	end

	// halt handshakes: ack once the peripheral reports its task done
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_halt_req <= 32'h00000000;
			o_halt_ack <= 32'h00000000;
		end else begin
			o_halt_req <= i_halt_req;
			o_halt_ack <= o_halt_req & i_halt_req & (o_halt_ack | i_periph_idle);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_counter <= 32'h00000000;
		end else begin
			o_counter <= cnt_q;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_sleep_wake;
		o_sleep && wake_any ##1 o_wake_req;
	endsequence

	entry_needs_wait_a: assert property (
		$rose(o_sleep) |-> $past(enter)
	) else $error("sleep entered without wait");

	no_source_stays_a: assert property (
		o_sleep && !wake_any |=> o_sleep
	) else $error("sleep left without a wake event");

	wake_ends_sleep_a: assert property (
		o_sleep && wake_any |=> !o_sleep && o_wake_req
	) else $error("wake event did not end sleep");

	resume_cores_a: assert property (
		s_sleep_wake |=> o_resume_core == waited_q && !o_sleep
	) else $error("waiting cores not resumed");

	clock_default_a: assert property (
		o_wake_req |-> o_sysclk_sel == `SLPWK_SYSCLK_IRC16M && o_irc16m_en
	) else $error("wake without internal clock");

	force_irc_a: assert property (
		$rose(o_sleep) && $past(o_sysclk_sel) != `SLPWK_SYSCLK_IRC16M
			|-> o_prev_clk_keep && o_irc16m_en
	) else $error("old clock not kept at entry");

	match_bits_a: assert property (
		ev_match_q |-> cnt_q[21:10] == cfg_q.counter_match_value && cnt_q[9:0] == 10'h000
	) else $error("match event on wrong count");

	rollover_a: assert property (
		ev_roll_q |-> cnt_q == 32'h00000000 && $past(cnt_q) == 32'hffffffff
	) else $error("rollover event without rollover");

	pit_gated_a: assert property (
		ev_pit_q |-> $past(cfg_q.counter_enable && cfg_q.pit_enable)
	) else $error("periodic event while disabled");

	cfg_frozen_a: assert property (
		o_sleep && $past(o_sleep) |-> $stable(cfg_q)
	) else $error("configuration changed in sleep");

	halt_ack_a: assert property (
		(o_halt_ack & ~o_halt_req) == 32'h00000000
	) else $error("acknowledge without request");

	cause_set_a: assert property (
		o_wake_req |-> o_cause != 4'h0
	) else $error("wake without cause flag");

endmodule

//--- slpwk_core_model.sv
// partner model: cores and peripherals around the sleep controller
// assumes a free-running i_clk; i_go asks for one sleep entry
`timescale 1ns/10ps
module slpwk_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_go,
	input  wire logic [1:0]  i_wait_mask,
	input  wire logic [1:0]  i_sel,
	input  wire logic [1:0]  i_active,
	input  wire logic [31:0] i_halt_ack,
	output logic             o_sleep_req,
	output logic [1:0]       o_core_active,
	output logic [1:0]       o_core_wait,
	output logic             o_sysclk_load,
	output logic [1:0]       o_sysclk_sel,
	output logic [31:0]      o_halt_req,
	output logic [31:0]      o_periph_idle
);
	int busy;

	// software entry sequence; i_sel other than 00 is a deliberate slip
	initial begin
		o_core_active = 2'h3;
		o_sleep_req = 1'b0;
		o_core_wait = 2'h0;
		o_sysclk_load = 1'b0;
		o_sysclk_sel = 2'h0;
		o_halt_req = 32'h0;
		o_periph_idle = 32'h0;
		busy = 0;
		forever begin
			@(posedge i_go);
			o_core_active = i_active;
			@(negedge i_clk);
			o_halt_req = 32'hffffffff;
			while (i_halt_ack !== 32'hffffffff) @(negedge i_clk);
			o_sysclk_sel = i_sel;
			o_sysclk_load = 1'b1;
			@(negedge i_clk);
			o_sysclk_load = 1'b0;
			o_sleep_req = 1'b1;
			o_core_wait = i_wait_mask;
			@(negedge i_go);
			@(negedge i_clk);
			o_sleep_req = 1'b0;
			o_core_wait = 2'h0;
			o_halt_req = 32'h0;
		end
	end

	// peripherals drain pending transfers before reporting idle
	always @(negedge i_clk) begin
		if (o_halt_req == 32'h0) busy = 0;
		else if (busy < 8) busy++;
		o_periph_idle = (busy >= 8) ? 32'hffffffff : 32'h0;
	end
endmodule

//--- slpwk_tb.sv
// self-checking bench for the sleep and wake-up controller
// assumes slpwk_core_model as software side; oscillators made here
`timescale 1ns/10ps
module testbench;
	logic                    clk, rstn, go;
	logic [3:0]              osc;
	logic [31:0]             pins;
	logic [1:0]              wmask, sel, amask;
	slpwk_pkg::slpwk_cfg_s   cfg;
	slpwk_pkg::slpwk_cause_s clr, cause;
	logic                    sreq, load, sleep, wreq, i16, keep, i128;
	logic [1:0]              act, cwait, msel, resume, osel;
	logic [31:0]             hreq, idle, ohreq, hack, cnt;
	int                      errors, n_compared;

	slpwk_core_model model (.i_clk(clk), .i_go(go), .i_wait_mask(wmask), .i_sel(sel),
		.i_active(amask),
		.i_halt_ack(hack), .o_sleep_req(sreq), .o_core_active(act), .o_core_wait(cwait),
		.o_sysclk_load(load), .o_sysclk_sel(msel), .o_halt_req(hreq), .o_periph_idle(idle));

	slpwk_ctrl DUT (.i_clk(clk), .i_reset_n(rstn), .i_osc(osc), .i_cfg(cfg), .i_pins(pins),
		.i_sleep_req(sreq), .i_core_active(act), .i_core_wait(cwait), .i_sysclk_load(load),
		.i_sysclk_sel(msel), .i_halt_req(hreq), .i_periph_idle(idle), .i_cause_clear(clr),
		.o_sleep(sleep), .o_wake_req(wreq), .o_resume_core(resume), .o_sysclk_sel(osel),
		.o_irc16m_en(i16), .o_prev_clk_keep(keep), .o_irc128k_en(i128),
		.o_halt_req(ohreq), .o_halt_ack(hack), .o_cause(cause), .o_counter(cnt));

	// 40 mhz clock; oscillators slow enough for the synchronisers
	initial begin
		clk = 0;
		osc = 4'h0;
		forever #12.5 clk = ~clk;
	end
	always #50 osc[3] = ~osc[3];
	always #100 osc[2] = ~osc[2];
	always #200 osc[1] = ~osc[1];

	task automatic check(input string w, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", w, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// short reset, then new configuration; 40 cycles let the pin detector arm
	task automatic setup(input slpwk_pkg::slpwk_cfg_s c);
		@(negedge clk) rstn = 0;
		cfg = '0;
		repeat (4) @(negedge clk);
		rstn = 1;
		cfg = c;
		repeat (40) @(negedge clk);
	endtask

	task automatic enter(input logic [1:0] m, input logic [1:0] s, input logic exp);
		int n;
		wmask = m;
		sel = s;
		@(negedge clk) go = 1;
		wait (ohreq === 32'hffffffff);
		#1 check("ack before idle", hack, 32'h0);
		for (n = 0; n < 200 && sleep !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		check("sleep entered", sleep, exp);
		check("ack after idle", hack, 32'hffffffff);
	endtask

	task automatic wake(input logic [3:0] ce, input int lim);
		int n;
		for (n = 0; n < lim && wreq !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		check("wake pulse", wreq, 1'b1);
		check("cause", cause, ce);
		check("awake", sleep, 1'b0);
		check("sysclk", osel, 2'h0);
		go = 0;
		@(posedge clk);
		#1 check("resume", resume, wmask);
		check("prev clk", keep, 1'b0);
	endtask

	// wrong edge first where only one edge is selected, then the right one
	task automatic pin_case(input int i, input logic r, input logic f, input logic w);
		slpwk_pkg::slpwk_cfg_s c;
		c = '0;
		c.pin_wake_enable[i] = 1'b1;
		c.pin_rise_select[i] = r;
		c.pin_fall_select[i] = f;
		c.wake_sync_clock_select = w;
		c.slow_osc_sleep_keep = w;
		@(negedge clk) pins[i] = r & !f;
		setup(c);
		enter(2'b11, {1'b0, w}, 1'b1);
		check("prev clk kept", keep, w);
		check("irc16 on", i16, 1'b1);
		if (w) check("irc128 on", i128, 1'b1);
		@(negedge clk) pins[i] = !pins[i];
		if (!(r & f)) begin
			repeat (100) @(posedge clk);
			#1 check("wrong edge", sleep, 1'b1);
			@(negedge clk) pins[i] = !pins[i];
		end
		wake(4'h1, 80);
	endtask

	// prescaled counter sources (16 MHz by 512, 128 kHz): one prescaler tick, periodic compare 0 wakes on it
	task automatic tick_case(input logic [1:0] s, input logic d);
		slpwk_pkg::slpwk_cfg_s c;
		c = '0;
		c.counter_enable = 1'b1;
		c.counter_clock_select = s;
		c.fast_div512 = d;
		c.pit_enable = 1'b1;
		c.pit_wake_enable = 1'b1;
		setup(c);
		enter(2'b11, 2'b00, 1'b1);
		wake(4'h2, 4300);
		check("one tick", cnt, 32'h00000001);
	endtask

	// watchdog well beyond the longest expected run
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		tally_and_finish;
	end

	initial begin
		slpwk_pkg::slpwk_cfg_s c;
		errors = 0;
		n_compared = 0;
		rstn = 0;
		go = 0;
		pins = 32'h0;
		wmask = 2'h3;
		amask = 2'h3;
		sel = 2'h0;
		cfg = '0;
		clr = '0;
		repeat (16) @(negedge clk);
		rstn = 1;
		@(posedge clk);
		#1 check("reset sysclk", osel, 2'h0);
		check("reset irc16", i16, 1'b1);
		enter(2'b01, 2'b00, 1'b0);
		go = 0;
		// periodic timer armed but counter off, pins not enabled
		c = '0;
		c.pit_enable = 1'b1;
		c.pit_wake_enable = 1'b1;
		c.counter_clock_select = 2'h3;
		setup(c);
		enter(2'b11, 2'b00, 1'b1);
		repeat (6) begin
			repeat (50) @(negedge clk);
			pins = ~pins;
		end
		check("no source", sleep, 1'b1);
		go = 0;
		pins = 32'h0;
		setup(c);
		check("reset exit", sleep, 1'b0);
		// periodic timer beats the match and the idle pin
		c.counter_enable = 1'b1;
		c.counter_clock_select = 2'h2;
		c.pit_compare = 10'h003;
		c.counter_wake_enable = 1'b1;
		c.counter_match_value = 12'h001;
		c.pin_wake_enable[5] = 1'b1;
		c.pin_rise_select[5] = 1'b1;
		setup(c);
		amask = 2'b10;
		enter(2'b10, 2'b00, 1'b1);
		wake(4'h2, 300);
		amask = 2'h3;
		// match on bits 21:10 after a rewrite while counting
		c = '0;
		c.counter_enable = 1'b1;
		c.counter_clock_select = 2'h3;
		c.counter_wake_enable = 1'b1;
		c.rollover_wake_enable = 1'b1;
		c.counter_match_value = 12'h005;
		setup(c);
		@(negedge clk) cfg.counter_match_value = 12'h001;
		enter(2'b11, 2'b00, 1'b1);
		wake(4'h8, 6000);
		check("match count", cnt >= 32'h00000400 && cnt < 32'h00000406, 1'b1);
		pin_case(5, 1'b1, 1'b0, 1'b1);
		pin_case(31, 1'b0, 1'b1, 1'b0);
		pin_case(31, 1'b1, 1'b1, 1'b0);
		tick_case(2'h2, 1'b1);
		tick_case(2'h1, 1'b0);
		tally_and_finish;
	end
endmodule
